// ---- shared/dp_psr_pkg.sv ----
package dp_psr_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [19:0] OFF_DATA_M1 = 20'h60030;
  localparam logic [19:0] OFF_DATA_N1 = 20'h60034;
  localparam logic [19:0] OFF_DATA_M2 = 20'h60038;
  localparam logic [19:0] OFF_DATA_N2 = 20'h6003c;
  localparam logic [19:0] OFF_LINK_M1 = 20'h60040;
  localparam logic [19:0] OFF_LINK_N1 = 20'h60044;
  localparam logic [19:0] OFF_LINK_M2 = 20'h60048;
  localparam logic [19:0] OFF_LINK_N2 = 20'h6004c;
  localparam logic [19:0] OFF_CTRL = 20'h60090;
  localparam logic [19:0] OFF_STAT = 20'h60094;
  localparam logic [19:0] OFF_VSC = 20'h600a0;

  // ----------------------------------------------------------------------
  // Ratio set layout and reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] DATA_M_RESET = 32'h07e0_0000;
  localparam logic [31:0] DATA_M_MASK = 32'h7eff_ffff;
  localparam logic [31:0] VALUE_MASK = 32'h00ff_ffff;
  localparam logic [1:0] IDX_DATA_M = 2'h0;
  localparam logic [1:0] IDX_DATA_N = 2'h1;
  localparam logic [1:0] IDX_LINK_M = 2'h2;
  localparam logic [1:0] IDX_LINK_N = 2'h3;
  localparam int TU_LO = 25;

  // ----------------------------------------------------------------------
  // Control, status and SDP fields
  // ----------------------------------------------------------------------
  localparam int CTL_ENABLE = 0;
  localparam int CTL_RESET = 1;
  localparam int CTL_MODE_LO = 2;
  localparam int CTL_SINGLE = 12;
  localparam int CTL_ENTRY = 13;
  localparam int CTL_TX_ON = 14;
  localparam int CTL_DOUBLE = 15;
  localparam int CTL_DELAY_LO = 16;
  localparam int CTL_THRESH_LO = 24;
  localparam logic [2:0] MODE_SW = 3'h1;
  localparam logic [2:0] MODE_HW = 3'h2;
  localparam int VSC_FREQ_LO = 30;
  localparam logic [31:0] VSC_DB_MASK = 32'h0000_ffff;
  localparam logic [1:0] SDP_EVERY = 2'h1;
  localparam logic [1:0] SDP_ONCE = 2'h2;
  localparam logic [1:0] STBY_IDLE = 2'h0;
  localparam logic [1:0] STBY_FETCH_STOPPED = 2'h1;
  localparam logic [1:0] STBY_TRUNK_GATED = 2'h2;
  localparam logic [7:0] REPEAT_MAX = 8'hff;

  // ----------------------------------------------------------------------
  // Self refresh states and their reported codes
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_DISABLED = 6'h01,
    ST_INACTIVE = 6'h02,
    ST_TO_ACTIVE = 6'h04,
    ST_ACTIVE = 6'h08,
    ST_SINGLE = 6'h10,
    ST_EXIT = 6'h20
  } psr_state_t;

  function automatic logic [2:0] state_code(input psr_state_t s);
    case (s)
      ST_INACTIVE: state_code = 3'h1;
      ST_TO_ACTIVE: state_code = 3'h2;
      ST_ACTIVE: state_code = 3'h3;
      ST_SINGLE: state_code = 3'h4;
      ST_EXIT: state_code = 3'h5;
      default: state_code = 3'h0;
    endcase
  endfunction

endpackage

// ---- shared/ratio_if.sv ----
interface ratio_if;
  logic wr_en;
  logic [1:0] wr_idx;
  logic [31:0] wdata;
  logic vblank;
  logic [3:0][31:0] pend;
  logic [23:0] data_m;
  logic [23:0] data_n;
  logic [23:0] link_m;
  logic [23:0] link_n;
  logic [6:0] tu_size;
  modport bank (input wr_en, wr_idx, wdata, vblank,
    output pend, data_m, data_n, link_m, link_n, tu_size);
  modport ctrl (output wr_en, wr_idx, wdata, vblank,
    input pend, data_m, data_n, link_m, link_n, tu_size);
endinterface

// ---- design/ratio_bank.sv ----
module ratio_bank
  import dp_psr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  ratio_if.bank rb
);

  logic armed;
  wire arm_write = rb.wr_en && (rb.wr_idx == IDX_LINK_N);
  wire [31:0] wr_mask = (rb.wr_idx == IDX_DATA_M) ? DATA_M_MASK : VALUE_MASK;

  // ----------------------------------------------------------------------
  // Pending copies and the live set that the link sees
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb.pend <= {32'h0, 32'h0, 32'h0, DATA_M_RESET};
    end else if (rb.wr_en) begin
      rb.pend[rb.wr_idx] <= rb.wdata & wr_mask;
    end
  end

  // An arming write in the vblank cycle stays armed for the next vblank.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else begin
      armed <= arm_write || (armed && !rb.vblank); // [RULE5]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb.data_m <= 24'h0;
      rb.data_n <= 24'h0;
      rb.link_m <= 24'h0;
      rb.link_n <= 24'h0;
      rb.tu_size <= 7'h40;
    end else if (rb.vblank && armed) begin // [RULE5]
      rb.data_m <= rb.pend[IDX_DATA_M][23:0]; // [RULE2]
      rb.data_n <= rb.pend[IDX_DATA_N][23:0]; // [RULE2]
      rb.link_m <= rb.pend[IDX_LINK_M][23:0];
      rb.link_n <= rb.pend[IDX_LINK_N][23:0];
      rb.tu_size <= {1'b0, rb.pend[IDX_DATA_M][TU_LO +: 6]} + 7'h1; // [RULE1]
    end
  end

  tu_plus_one_a: assert property ( // [RULE1]
    @(posedge clk) disable iff (!rst_n)
    (rb.vblank && armed) |=>
      rb.tu_size == {1'b0, $past(rb.pend[IDX_DATA_M][30:25])} + 7'h1)
    else $error("Transfer unit size is not the programmed value plus one.");

  unarmed_hold_a: assert property ( // [RULE5]
    @(posedge clk) disable iff (!rst_n)
    !armed ##1 !armed |-> $stable(rb.link_n) && $stable(rb.data_m))
    else $error("Live ratio set changed without an arming write.");

endmodule // ratio_bank

// ---- design/pll_delay.sv ----
module pll_delay (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_down,
  input wire logic [7:0] delay,
  output logic pll_off
);

  logic [7:0] count;

  // The display PLL goes off delay+1 cycles after the link drops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h0;
      pll_off <= 1'b0;
    end else if (!link_down) begin
      count <= 8'h0;
      pll_off <= 1'b0;
    end else if (!pll_off) begin
      if (count == delay) begin
        pll_off <= 1'b1; // [RULE13]
      end else begin
        count <= count + 8'h1;
      end
    end
  end

  pll_wait_a: assert property ( // [RULE13]
    @(posedge clk) disable iff (!rst_n)
    $rose(pll_off) |-> $past(link_down) && $past(count) == $past(delay))
    else $error("Display PLL powered down before the programmed delay.");

endmodule // pll_delay

// ---- design/dp_psr_ctrl.sv ----
// Notes on behaviour
// [RULE1] Transfer unit size is register bits 30:25 plus one; reset gives 64.
// [RULE2] Data M and N low 24 bits feed only the ratio accumulator.
// [RULE3] Selected link M value goes out in the Main Stream Attributes.
// [RULE4] Selected link N value goes out in attributes and in VB-ID.
// [RULE5] Each ratio set updates at vblank only after its link N write.
// [RULE6] Mode field: 010 hardware timer, 001 software timer, others reserved.
// [RULE7] Hardware timer enters active when identical frames exceed threshold.
// [RULE8] Hardware timer leaves active on a frame buffer register write.
// [RULE9] Software timer follows the entry request bit into and out of active.
// [RULE10] Software toggles the entry request at most once per vblank.
// [RULE11] Single update request runs one frame at once, then back to active.
// [RULE12] Self refresh reset returns to inactive and clears itself.
// [RULE13] Display PLL powers down a programmed delay after the link.
// [RULE14] Double-frame bit sends two active-setting frames on entry.
// [RULE15] Transmitter-state bit keeps link idling in active, else off.
// [RULE16] Standby field: 0 fetching, 1 fetch stopped, 2 trunk gated.
// [RULE17] Repeat-frame counter saturates at 255.
// [RULE18] Status flag shows an SDP was sent this frame.
// [RULE19] Software waits while the in-transition flag is set.
// [RULE20] Current-state field reports the state machine code.
// [RULE21] SDP frequency: 00 off, 01 every frame, 10 once.
// [RULE22] While enabling, one SDP per frame until active.
// [RULE23] Disabled while enable is clear; inactive once enable is set.
module dp_psr_ctrl
  import dp_psr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [19:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_vblank,
  input wire logic i_frame_identical,
  input wire logic i_fb_write,
  input wire logic i_sink_active,
  input wire logic i_ratio_sel,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic [23:0] o_data_m,
  output logic [23:0] o_data_n,
  output logic [6:0] o_tu_size,
  output logic [23:0] o_link_m,
  output logic [23:0] o_link_n,
  output logic [23:0] o_vbid_link_n,
  output logic o_tx_enable,
  output logic o_idle_only,
  output logic o_fetch_stop,
  output logic o_pll_power_down,
  output logic o_sdp_send,
  output logic o_sdp_active
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  function automatic logic [2:0] ratio_index(input logic [19:0] a);
    ratio_index = {a[3], a[6], a[2]};
  endfunction

  wire ratio_hit = (i_reg_addr >= OFF_DATA_M1) &&
                   (i_reg_addr <= OFF_LINK_N2) &&
                   (i_reg_addr[1:0] == 2'h0);
  wire [2:0] ratio_loc = ratio_index(i_reg_addr);
  wire wr_ctrl = i_reg_wr && (i_reg_addr == OFF_CTRL);
  wire wr_vsc = i_reg_wr && (i_reg_addr == OFF_VSC);

  ratio_if rb0 ();
  ratio_if rb1 ();

  assign rb0.wr_en = i_reg_wr && ratio_hit && !ratio_loc[2];
  assign rb1.wr_en = i_reg_wr && ratio_hit && ratio_loc[2];
  assign rb0.wr_idx = ratio_loc[1:0];
  assign rb1.wr_idx = ratio_loc[1:0];
  assign rb0.wdata = i_reg_wdata;
  assign rb1.wdata = i_reg_wdata;
  assign rb0.vblank = i_vblank;
  assign rb1.vblank = i_vblank;

  ratio_bank u_bank_primary (
    .clk(i_ref_clk),
    .rst_n(rst_n),
    .rb(rb0.bank)
  );

  ratio_bank u_bank_secondary (
    .clk(i_ref_clk),
    .rst_n(rst_n),
    .rb(rb1.bank)
  );

  // ----------------------------------------------------------------------
  // Control and SDP registers
  // ----------------------------------------------------------------------
  logic enable;
  logic [2:0] mode;
  logic entry_req;
  logic tx_on;
  logic double_frame;
  logic [7:0] pll_delay_cycles;
  logic [7:0] threshold;
  logic single_rb;
  logic psr_reset;
  logic single_req;
  logic [1:0] sdp_freq;
  logic [15:0] sdp_db;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= 1'b0;
      mode <= 3'h0;
      entry_req <= 1'b0;
      tx_on <= 1'b0;
      double_frame <= 1'b0;
      pll_delay_cycles <= 8'h0;
      threshold <= 8'h0;
    end else if (wr_ctrl) begin
      enable <= i_reg_wdata[CTL_ENABLE];
      mode <= i_reg_wdata[CTL_MODE_LO +: 3];
      entry_req <= i_reg_wdata[CTL_ENTRY];
      tx_on <= i_reg_wdata[CTL_TX_ON];
      double_frame <= i_reg_wdata[CTL_DOUBLE];
      pll_delay_cycles <= i_reg_wdata[CTL_DELAY_LO +: 8];
      threshold <= i_reg_wdata[CTL_THRESH_LO +: 8];
    end
  end

  // Reset and single update act as one-cycle strobes; reset reads as zero, single update reads back from single_rb.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      psr_reset <= 1'b0;
      single_req <= 1'b0;
    end else begin
      psr_reset <= wr_ctrl && i_reg_wdata[CTL_RESET]; // [RULE12]
      single_req <= wr_ctrl && i_reg_wdata[CTL_SINGLE]; // [RULE11]
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdp_freq <= 2'h0;
      sdp_db <= 16'h0;
    end else if (wr_vsc) begin
      sdp_freq <= i_reg_wdata[VSC_FREQ_LO +: 2];
      sdp_db <= i_reg_wdata[15:0] & VSC_DB_MASK[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // Frame counters
  // ----------------------------------------------------------------------
  logic [7:0] repeat_count;
  logic [1:0] entry_frames;
  psr_state_t state;
  psr_state_t next_state;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      repeat_count <= 8'h0;
    end else if (i_fb_write || (i_vblank && !i_frame_identical)) begin
      repeat_count <= 8'h0;
    end else if (i_vblank && repeat_count != REPEAT_MAX) begin
      repeat_count <= repeat_count + 8'h1; // [RULE17]
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      entry_frames <= 2'h0;
    end else if (state != ST_TO_ACTIVE) begin
      entry_frames <= double_frame ? 2'h2 : 2'h1; // [RULE14]
    end else if (i_vblank && entry_frames != 2'h0) begin
      entry_frames <= entry_frames - 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Self refresh state machine
  // ----------------------------------------------------------------------
  wire hw_mode = (mode == MODE_HW); // [RULE6]
  wire sw_mode = (mode == MODE_SW); // [RULE6]
  wire hw_enter = hw_mode && (repeat_count > threshold); // [RULE7]
  wire sw_enter = sw_mode && entry_req; // [RULE9]
  wire leave_active = (hw_mode && i_fb_write) ||
                      (sw_mode && !entry_req);
  wire entry_done = (entry_frames == 2'h0) && i_sink_active;

  always_comb begin
    next_state = state;
    if (!enable) begin
      next_state = ST_DISABLED; // [RULE23]
    end else if (psr_reset) begin
      next_state = ST_INACTIVE; // [RULE12]
    end else begin
      case (state)
        ST_DISABLED: next_state = ST_INACTIVE; // [RULE23]
        ST_INACTIVE: begin
          if (hw_enter || sw_enter) begin // [RULE7] [RULE9]
            next_state = ST_TO_ACTIVE;
          end
        end
        ST_TO_ACTIVE: begin
          if (entry_done) begin
            next_state = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (leave_active) begin // [RULE8] [RULE9]
            next_state = ST_EXIT;
          end else if (single_req) begin
            next_state = ST_SINGLE; // [RULE11]
          end
        end
        ST_SINGLE: begin
          if (i_vblank) begin
            next_state = ST_ACTIVE; // [RULE11]
          end
        end
        ST_EXIT: begin
          if (i_vblank) begin
            next_state = ST_INACTIVE;
          end
        end
        default: next_state = ST_DISABLED;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_DISABLED;
    end else begin
      state <= next_state;
    end
  end

  // Readback of the single update bit only refreshes at vblank.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      single_rb <= 1'b0;
    end else if (i_vblank) begin
      single_rb <= (state == ST_SINGLE) || single_req; // [RULE11]
    end
  end

  // ----------------------------------------------------------------------
  // SDP scheduling
  // ----------------------------------------------------------------------
  logic sdp_sent;
  logic once_done;
  wire enabling = enable &&
                  ((state == ST_INACTIVE) || (state == ST_TO_ACTIVE));
  wire send_now = i_vblank &&
                  (enabling || // [RULE22]
                   (sdp_freq == SDP_EVERY) || // [RULE21]
                   ((sdp_freq == SDP_ONCE) && !once_done)); // [RULE21]

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      once_done <= 1'b0;
      sdp_sent <= 1'b0;
      o_sdp_send <= 1'b0;
      o_sdp_active <= 1'b0;
    end else begin
      once_done <= (send_now && !enabling && sdp_freq == SDP_ONCE) ||
                   (once_done && !wr_vsc);
      if (i_vblank) begin
        sdp_sent <= send_now; // [RULE18]
      end
      o_sdp_send <= send_now;
      o_sdp_active <= (next_state == ST_TO_ACTIVE) || // [RULE14]
                      (next_state == ST_ACTIVE);
    end
  end

  // ----------------------------------------------------------------------
  // Link outputs and power control
  // ----------------------------------------------------------------------
  wire [23:0] sel_link_m = i_ratio_sel ? rb1.link_m : rb0.link_m;
  wire [23:0] sel_link_n = i_ratio_sel ? rb1.link_n : rb0.link_n;
  wire active_now = (state == ST_ACTIVE);
  wire [1:0] standby = !active_now ? STBY_IDLE :
                       o_pll_power_down ? STBY_TRUNK_GATED :
                       STBY_FETCH_STOPPED;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_data_m <= 24'h0;
      o_data_n <= 24'h0;
      o_tu_size <= 7'h40;
      o_link_m <= 24'h0;
      o_link_n <= 24'h0;
      o_vbid_link_n <= 24'h0;
      o_tx_enable <= 1'b1;
      o_idle_only <= 1'b0;
      o_fetch_stop <= 1'b0;
    end else begin
      o_data_m <= i_ratio_sel ? rb1.data_m : rb0.data_m; // [RULE2]
      o_data_n <= i_ratio_sel ? rb1.data_n : rb0.data_n; // [RULE2]
      o_tu_size <= i_ratio_sel ? rb1.tu_size : rb0.tu_size; // [RULE1]
      o_link_m <= sel_link_m; // [RULE3]
      o_link_n <= sel_link_n; // [RULE4]
      o_vbid_link_n <= sel_link_n; // [RULE4]
      o_tx_enable <= !(next_state == ST_ACTIVE) || tx_on; // [RULE15]
      o_idle_only <= (next_state == ST_ACTIVE) && tx_on; // [RULE15]
      o_fetch_stop <= (next_state == ST_ACTIVE);
    end
  end

  pll_delay u_pll_delay (
    .clk(i_ref_clk),
    .rst_n(rst_n),
    .link_down(!o_tx_enable),
    .delay(pll_delay_cycles),
    .pll_off(o_pll_power_down)
  );

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  wire in_transition = (state == ST_TO_ACTIVE) && !i_sink_active; // [RULE19]
  wire [31:0] ctrl_word = {threshold, pll_delay_cycles, double_frame,
                           tx_on, entry_req, single_rb, 7'h0, mode,
                           1'b0, enable};
  wire [31:0] stat_word = {standby, 6'h0, repeat_count, 7'h0, // [RULE16]
                           sdp_sent, in_transition, 4'h0,
                           state_code(state)}; // [RULE20]
  wire [31:0] ratio_word = ratio_loc[2] ? rb1.pend[ratio_loc[1:0]] :
                           rb0.pend[ratio_loc[1:0]];
  wire [31:0] read_word = ratio_hit ? ratio_word :
                          (i_reg_addr == OFF_CTRL) ? ctrl_word :
                          (i_reg_addr == OFF_STAT) ? stat_word :
                          (i_reg_addr == OFF_VSC) ?
                            {sdp_freq, 14'h0, sdp_db} : 32'h0;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= 32'h0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= read_word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  disabled_hold_a: assert property ( // [RULE23]
    @(posedge i_ref_clk) disable iff (!rst_n)
    !enable |=> state == ST_DISABLED)
    else $error("State left disabled while self refresh is off.");

  hw_entry_a: assert property ( // [RULE7]
    @(posedge i_ref_clk) disable iff (!rst_n)
    (enable && !psr_reset && state == ST_INACTIVE && hw_mode &&
     repeat_count > threshold) |=> state == ST_TO_ACTIVE)
    else $error("Hardware timer did not start entry past the threshold.");

  hw_exit_a: assert property ( // [RULE8]
    @(posedge i_ref_clk) disable iff (!rst_n)
    (enable && !psr_reset && active_now && hw_mode && i_fb_write)
      |=> state == ST_EXIT)
    else $error("Frame buffer write did not end the active state.");

  sw_follow_a: assert property ( // [RULE9]
    @(posedge i_ref_clk) disable iff (!rst_n)
    (enable && !psr_reset && state == ST_INACTIVE && sw_mode && entry_req)
      |=> state == ST_TO_ACTIVE)
    else $error("Software entry request was not followed.");

  psr_reset_a: assert property ( // [RULE12]
    @(posedge i_ref_clk) disable iff (!rst_n)
    (wr_ctrl && i_reg_wdata[CTL_RESET] && i_reg_wdata[CTL_ENABLE])
      |=> psr_reset ##1 (state == ST_INACTIVE && !psr_reset))
    else $error("Self refresh reset did not return to inactive.");

  repeat_sat_a: assert property ( // [RULE17]
    @(posedge i_ref_clk) disable iff (!rst_n)
    (repeat_count == REPEAT_MAX && !i_fb_write && i_frame_identical)
      |=> repeat_count == REPEAT_MAX)
    else $error("Repeat-frame counter rolled over.");

  link_out_a: assert property ( // [RULE3]
    @(posedge i_ref_clk) disable iff (!rst_n)
    ##1 o_link_m == $past(sel_link_m) && o_vbid_link_n == o_link_n)
    else $error("Attribute link values do not follow the selected set.");

  tx_idle_a: assert property ( // [RULE15]
    @(posedge i_ref_clk) disable iff (!rst_n)
    active_now |-> o_tx_enable == $past(tx_on) &&
      o_idle_only == $past(tx_on))
    else $error("Transmitter state in active does not match its setting.");

  single_back_a: assert property ( // [RULE11]
    @(posedge i_ref_clk) disable iff (!rst_n)
    (state == ST_SINGLE && enable && !psr_reset && i_vblank)
      |=> active_now)
    else $error("Single frame update did not return to active.");

endmodule // dp_psr_ctrl

// ---- verif/sink_model.sv ----
module sink_model #(
  parameter int LAG = 3
) (
  input wire logic i_clk,
  input wire logic i_send,
  input wire logic i_act,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial o_ready = 1'b0;
  // The panel commits only after an SDP with the active setting.
  always @(posedge i_clk) begin
    if (i_act !== 1'b1) begin
      cnt <= 0;
      o_ready <= 1'b0;
    end else if (i_send === 1'b1 || cnt != 0) begin
      cnt <= cnt + 1;
      o_ready <= (cnt >= LAG);
    end
  end
endmodule // sink_model

// ---- verif/tb_top.sv ----
module tb_top
  import dp_psr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, vb = 0, same = 0, fbw = 0;
  logic sel = 0, sink, rv, tx, idle, fstop, pll, sdp, sact;
  logic [19:0] addr = '0;
  logic [31:0] wd = '0, rdat, v;
  logic [23:0] dm, dn, lm, ln, vn;
  logic [6:0] tu;
  int err_total = 0, checks_done = 0, sdps = 0, n;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (sdp === 1'b1) sdps <= sdps + 1;
  dp_psr_ctrl i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .i_vblank(vb),
    .i_frame_identical(same), .i_fb_write(fbw), .i_sink_active(sink),
    .i_ratio_sel(sel), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
    .o_data_m(dm), .o_data_n(dn), .o_tu_size(tu), .o_link_m(lm),
    .o_link_n(ln), .o_vbid_link_n(vn), .o_tx_enable(tx),
    .o_idle_only(idle), .o_fetch_stop(fstop), .o_pll_power_down(pll),
    .o_sdp_send(sdp), .o_sdp_active(sact));
  sink_model i_sink (.i_clk(clk), .i_send(sdp), .i_act(sact),
    .o_ready(sink));
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // The trailing cycle keeps two strobes from meeting in one step.
  task automatic wreg(input logic [19:0] a, input logic [31:0] d);
    addr = a;
    wd = d;
    wr = 1;
    cyc(1);
    wr = 0;
    cyc(1);
  endtask
  task automatic rreg(input logic [19:0] a, output logic [31:0] d);
    addr = a;
    rd = 1;
    cyc(1);
    rd = 0;
    for (int i = 0; i < 3 && rv !== 1'b1; i++) cyc(1);
    chk(rv, 1);
    d = rdat;
    cyc(1);
  endtask
  task automatic st(input logic [2:0] e);
    rreg(OFF_STAT, v);
    chk(v[2:0], e);
  endtask
  task automatic frm(input logic s);
    same = s;
    vb = 1;
    cyc(1);
    vb = 0;
    cyc(20);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #2_000_000;
    err_total++;
    report_and_stop;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    cyc(12);
    rst_n = 1;
    cyc(4);
    chk(tu, 64);
    rreg(OFF_DATA_M2, v);
    chk(v, DATA_M_RESET);
    rreg(20'h600fc, v);
    chk(v, 0);
    $display("test reset done");
    wreg(OFF_DATA_M1, 32'h8612_3456);
    wreg(OFF_DATA_N1, 32'hff00_0042);
    wreg(OFF_LINK_M1, 32'h0000_0777);
    wreg(OFF_LINK_N1, 32'h0000_0999);
    rreg(OFF_DATA_M1, v);
    chk(v, 32'h0612_3456);
    chk(ln, 0);
    frm(0);
    chk({dm, dn[7:0]}, 32'h1234_5642);
    chk(tu, 7'h4);
    chk(lm, 24'h777);
    chk({ln[11:0], vn[11:0]}, 24'h999_999);
    sel = 1;
    wreg(OFF_LINK_M2, 32'h0000_0555);
    frm(0);
    chk({lm, 1'b0, tu}, 32'h40);
    wreg(OFF_LINK_N2, 32'h0000_0aaa);
    frm(0);
    chk({lm[11:0], vn[11:0]}, 24'h555_aaa);
    sel = 0;
    for (int f = 0; f < 3; f++) begin
      n = sdps;
      wreg(OFF_VSC, 32'((f + 1) % 3) << VSC_FREQ_LO);
      frm(0);
      frm(0);
      chk(sdps - n, 2 - f);
    end
    $display("test ratio and sdp done");
    wreg(OFF_CTRL, 32'h0004_200d);
    cyc(2);
    st(3'h1);
    wreg(OFF_CTRL, 32'h0004_2005);
    cyc(2);
    st(3'h2);
    chk(v[7], 1);
    n = sdps;
    frm(0);
    st(3'h3);
    chk(v[7], 0);
    chk(v[31:30], STBY_TRUNK_GATED);
    chk({v[8], 31'(sdps - n)}, 32'h8000_0001);
    chk({tx, fstop, pll, sact}, 4'b0111);
    wreg(OFF_CTRL, 32'h0004_3005);
    st(3'h4);
    frm(0);
    st(3'h3);
    rreg(OFF_CTRL, v);
    chk(v[12], 1);
    wreg(OFF_CTRL, 32'h0004_0005);
    st(3'h5);
    frm(0);
    st(3'h1);
    chk({tx, pll}, 2'b10);
    n = sdps;
    wreg(OFF_CTRL, 32'h0004_a005);
    cyc(2);
    frm(0);
    st(3'h2);
    frm(0);
    st(3'h3);
    chk(sdps - n, 2);
    wreg(OFF_CTRL, 32'h0004_0005);
    frm(0);
    wreg(OFF_CTRL, 32'h0004_6005);
    cyc(2);
    frm(0);
    st(3'h3);
    chk(v[31:30], STBY_FETCH_STOPPED);
    chk({tx, idle, pll}, 3'b110);
    wreg(OFF_CTRL, 0);
    st(3'h0);
    $display("test software timer done");
    wreg(OFF_CTRL, 32'h0204_0009);
    frm(0);
    repeat (2) frm(1);
    st(3'h1);
    chk(v[23:16], 8'h2);
    repeat (2) frm(1);
    st(3'h3);
    fbw = 1;
    cyc(1);
    fbw = 0;
    st(3'h5);
    frm(0);
    repeat (4) frm(1);
    wreg(OFF_CTRL, 32'hff04_000b);
    st(3'h1);
    rreg(OFF_CTRL, v);
    chk(v, 32'hff04_0009);
    repeat (260) frm(1);
    st(3'h1);
    chk(v[23:16], REPEAT_MAX);
    $display("test hardware timer done");
    report_and_stop;
  end
endmodule // tb_top
